// >>> logic/port_pins_consts.svh
`ifndef PORT_PINS_CONSTS_SVH
`define PORT_PINS_CONSTS_SVH

// ------------------------------------------------------------
// timing counts and port reset value
// ------------------------------------------------------------
`define OSC_PER_MACHINE_CYCLE   4'd12
`define OSC_PER_MC_MAX          4'd11
`define RESET_QUAL_MCYCLES      2'd2
`define PORT_RESET_VALUE        8'hFF

// ------------------------------------------------------------
// port 3 and port 1 bit positions
// ------------------------------------------------------------
`define P3_RX_BIT               0
`define P3_TX_BIT               1
`define P3_IRQ0_BIT             2
`define P3_IRQ1_BIT             3
`define P3_T0_BIT               4
`define P3_T1_BIT               5
`define P3_CMP_BIT              6
`define P1_CMP_POS_BIT          0
`define P1_CMP_NEG_BIT          1

`endif

// >>> logic/port_pins_pkg.sv
package port_pins_pkg;

	typedef enum logic [1:0] {
		MODE_RUN   = 2'b00,
		MODE_IDLE  = 2'b01,
		MODE_PDOWN = 2'b10
	} power_mode_t;

	typedef struct packed {
		logic [7:0] p1_out;
		logic [7:0] p1_oe;
		logic [7:0] p3_out;
		logic [7:0] p3_oe;
	} pin_drive_t;

	typedef struct packed {
		logic serial_rx;
		logic ext_irq_zero_pin;
		logic ext_irq_one_pin;
		logic timer_zero_count_pin;
		logic timer_one_count_pin;
		logic comparator_pos_input;
		logic comparator_neg_input;
	} alt_in_t;

endpackage

// >>> logic/sync_2ff.sv
`timescale 1ns/1ps
// two-stage synchroniser for a bus of pin inputs
module sync_2ff #(
	parameter int W = 8
) (
	input  wire logic         clk_sys_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_state_t;

	sync_state_t st_reg;
	sync_state_t st_next;

	always_comb begin
		st_next    = st_reg;
		st_next.s1 = d_i;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q_o = st_reg.s2;
endmodule

// >>> logic/port_reset_clock_pins.sv
`timescale 1ns/1ps
`include "port_pins_consts.svh"
module port_reset_clock_pins (
	input  wire logic                     clk_sys_i,
	input  wire logic                     nrst_i,
	input  wire logic                     oscillator_input_i,
	input  wire logic                     reset_pin_i,
	input  wire logic [7:0]               p1_pin_i,
	input  wire logic [7:0]               p3_pin_i,
	input  wire logic                     comparator_out_i,
	input  wire logic                     latch_wr_p1_i,
	input  wire logic                     latch_wr_p3_i,
	input  wire logic [7:0]               latch_wdata_i,
	input  wire logic                     serial_tx_i,
	input  wire logic                     idle_req_i,
	input  wire logic                     pdown_req_i,
	input  wire logic                     irq_pending_i,
	input  wire logic                     prog_mode_i,
	input  wire logic                     prog_drive_i,
	input  wire logic [7:0]               prog_data_i,
	output logic                          oscillator_output_o,
	output port_pins_pkg::pin_drive_t     drive_o,
	output logic [7:0]                    p1_read_o,
	output logic [7:0]                    p3_read_o,
	output port_pins_pkg::alt_in_t        alt_o,
	output logic [7:0]                    prog_data_o,
	output logic [2:0]                    prog_ctrl_o,
	output logic                          osc_half_o,
	output logic                          mcycle_stb_o,
	output logic                          sys_reset_o,
	output logic                          cpu_run_o,
	output logic                          periph_run_o,
	output port_pins_pkg::power_mode_t    mode_o
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]                p1_latch;
		logic [7:0]                p3_latch;
		logic                      osc_prev;
		logic                      half;
		logic [3:0]                osc_cnt;
		logic                      mstb;
		logic [1:0]                rst_cnt;
		logic                      sys_rst;
		port_pins_pkg::power_mode_t mode;
		logic                      osc_drv;
		port_pins_pkg::pin_drive_t drive;
		logic [7:0]                p1_rd;
		logic [7:0]                p3_rd;
		port_pins_pkg::alt_in_t    alt;
		logic [7:0]                pdat;
		logic [2:0]                pctl;
		logic                      cpu_run;
		logic                      per_run;
	} top_state_t;

	top_state_t st_reg;
	top_state_t st_next;
	logic [17:0] sync_q;

	// every pin input passes two flops first
	sync_2ff #(
		.W (18)
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.d_i       ({oscillator_input_i, reset_pin_i, p1_pin_i, p3_pin_i}),
		.q_o       (sync_q)
	);

	logic       osc_s;
	logic       rst_s;
	logic [7:0] p1_s;
	logic [7:0] p3_s;
	assign osc_s = sync_q[17];
	assign rst_s = sync_q[16];
	assign p1_s  = sync_q[15:8];
	assign p3_s  = sync_q[7:0];

	always_comb begin
		logic       half_rise;
		logic [7:0] p3_eff;
		half_rise = 1'b0;
		p3_eff    = 8'h00;
		st_next   = st_reg;
		st_next.mstb = 1'b0;

		// ------------------------------------------------------------
		// clock path
		// ------------------------------------------------------------
		// oscillator stops; qualifier needs it, so a high pin restarts it
		if (st_reg.mode != port_pins_pkg::MODE_PDOWN || rst_s) begin
			st_next.osc_prev = osc_s;
			st_next.osc_drv  = ~osc_s;
			if (osc_s && !st_reg.osc_prev) begin
				st_next.half = ~st_reg.half;
				half_rise    = 1'b1;
			end
		end
		if (half_rise) begin
			if (st_reg.osc_cnt == `OSC_PER_MC_MAX) begin
				st_next.osc_cnt = 4'h0;
				st_next.mstb    = 1'b1;
			end else begin
				st_next.osc_cnt = st_reg.osc_cnt + 4'h1;
			end
		end

		// ------------------------------------------------------------
		// reset qualifier
		// ------------------------------------------------------------
		// restart on low
		if (!rst_s) begin
			st_next.rst_cnt = 2'b00;
			st_next.sys_rst = 1'b0;
		end else if (half_rise && st_reg.osc_cnt == `OSC_PER_MC_MAX) begin
			// two whole machine cycles; the first boundary only opens
			// the count, since the cycle before it was partly low
			if (st_reg.rst_cnt == `RESET_QUAL_MCYCLES) begin
				st_next.sys_rst = 1'b1;
			end else begin
				st_next.rst_cnt = st_reg.rst_cnt + 2'b01;
			end
		end

		// ------------------------------------------------------------
		// power modes
		// ------------------------------------------------------------
		unique case (st_reg.mode)
			port_pins_pkg::MODE_RUN: begin
				if (pdown_req_i) begin
					st_next.mode = port_pins_pkg::MODE_PDOWN;
				end else if (idle_req_i) begin
					st_next.mode = port_pins_pkg::MODE_IDLE;
				end
			end
			port_pins_pkg::MODE_IDLE: begin
				if (irq_pending_i || st_next.sys_rst) begin
					st_next.mode = port_pins_pkg::MODE_RUN;
				end
			end
			port_pins_pkg::MODE_PDOWN: begin
				if (st_next.sys_rst) begin
					st_next.mode = port_pins_pkg::MODE_RUN;
				end
			end
			default: st_next.mode = port_pins_pkg::MODE_RUN;
		endcase
		st_next.cpu_run = (st_next.mode == port_pins_pkg::MODE_RUN)
			&& !st_next.sys_rst;
		st_next.per_run = (st_next.mode != port_pins_pkg::MODE_PDOWN);

		// ------------------------------------------------------------
		// pin latches
		// ------------------------------------------------------------
		// pin high forces ones at once
		// only registers reset; ram lies outside
		if (rst_s) begin
			st_next.p1_latch = `PORT_RESET_VALUE;
			st_next.p3_latch = `PORT_RESET_VALUE;
		end else if (st_reg.cpu_run) begin
			if (latch_wr_p1_i) begin
				st_next.p1_latch = latch_wdata_i;
			end
			if (latch_wr_p3_i) begin
				st_next.p3_latch = latch_wdata_i;
			end
		end

		p3_eff = st_next.p3_latch;
		p3_eff[`P3_TX_BIT] = st_next.p3_latch[`P3_TX_BIT] & serial_tx_i;

		// quasi-bidirectional: drive low only, pull-ups outside
		st_next.drive.p1_out = 8'h00;
		st_next.drive.p1_oe  = ~st_next.p1_latch;
		st_next.drive.p3_out = 8'h00;
		st_next.drive.p3_oe  = ~p3_eff;
		st_next.drive.p3_oe[`P3_CMP_BIT] = 1'b0;
		// programming data path on port one
		if (prog_mode_i) begin
			st_next.drive.p1_out = prog_data_i;
			st_next.drive.p1_oe  = prog_drive_i ? 8'hFF : 8'h00;
		end

		// a latched one leaves the pin readable
		st_next.p1_rd = p1_s & st_next.p1_latch;
		st_next.p3_rd = p3_s & st_next.p3_latch;
		st_next.p3_rd[`P3_CMP_BIT] = comparator_out_i;

		st_next.alt.serial_rx            = p3_s[`P3_RX_BIT];
		st_next.alt.ext_irq_zero_pin     = p3_s[`P3_IRQ0_BIT];
		st_next.alt.ext_irq_one_pin      = p3_s[`P3_IRQ1_BIT];
		st_next.alt.timer_zero_count_pin = p3_s[`P3_T0_BIT];
		st_next.alt.timer_one_count_pin  = p3_s[`P3_T1_BIT];
		st_next.alt.comparator_pos_input = p1_s[`P1_CMP_POS_BIT];
		st_next.alt.comparator_neg_input = p1_s[`P1_CMP_NEG_BIT];

		st_next.pdat = p1_s;
		st_next.pctl = prog_mode_i ? p3_s[`P3_T1_BIT:`P3_IRQ1_BIT] : 3'b000;
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_reg          <= '0;
			st_reg.p1_latch <= `PORT_RESET_VALUE;
			st_reg.p3_latch <= `PORT_RESET_VALUE;
			st_reg.sys_rst  <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign oscillator_output_o = st_reg.osc_drv;
	assign drive_o             = st_reg.drive;
	assign p1_read_o           = st_reg.p1_rd;
	assign p3_read_o           = st_reg.p3_rd;
	assign alt_o               = st_reg.alt;
	assign prog_data_o         = st_reg.pdat;
	assign prog_ctrl_o         = st_reg.pctl;
	assign osc_half_o          = st_reg.half;
	assign mcycle_stb_o        = st_reg.mstb;
	assign sys_reset_o         = st_reg.sys_rst;
	assign cpu_run_o           = st_reg.cpu_run;
	assign periph_run_o        = st_reg.per_run;
	assign mode_o              = st_reg.mode;
endmodule

// >>> verif/port_pins_properties.sv
`timescale 1ns/1ps
module port_pins_properties (
	input wire logic                       clk_sys_i,
	input wire logic                       nrst_i,
	input wire logic                       oscillator_input_i,
	input wire logic                       reset_pin_i,
	input wire logic                       oscillator_output_o,
	input wire logic                       osc_half_o,
	input wire logic                       comparator_out_i,
	input wire port_pins_pkg::pin_drive_t  drive_o,
	input wire logic [7:0]                 p3_read_o,
	input wire logic                       mcycle_stb_o,
	input wire logic                       sys_reset_o,
	input wire logic                       cpu_run_o,
	input wire logic                       periph_run_o,
	input wire port_pins_pkg::power_mode_t mode_o
);
	logic       osc_q, seen_stb, pdown;
	logic [5:0] rise_cnt, hi_cnt, rise;

	assign rise  = {5'h00, oscillator_input_i & ~osc_q};
	assign pdown = (mode_o == port_pins_pkg::MODE_PDOWN);

	// first window after reset or power-down is partial, so it is skipped
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			osc_q    <= 1'b0;
			seen_stb <= 1'b0;
			rise_cnt <= 6'h00;
			hi_cnt   <= 6'h00;
		end else begin
			osc_q    <= oscillator_input_i;
			seen_stb <= (seen_stb | mcycle_stb_o) & ~sys_reset_o & ~pdown;
			rise_cnt <= mcycle_stb_o ? 6'h00 : rise_cnt + rise;
			hi_cnt   <= !reset_pin_i ? 6'h00 :
				(hi_cnt == 6'h3f) ? hi_cnt : hi_cnt + rise;
		end
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);

	chk_cmp_bit_idle: assert property (drive_o.p3_oe[6] == 1'b0)
		else $error("port three bit 6 driven");
	chk_p3_never_high: assert property (drive_o.p3_out == 8'h00)
		else $error("port three drives high");
	chk_cmp_read: assert property ($past(nrst_i) |->
		p3_read_o[6] == $past(comparator_out_i))
		else $error("bit 6 read not comparator");
	chk_mc_twelve: assert property (mcycle_stb_o && seen_stb |->
		rise_cnt + rise == 6'd12)
		else $error("machine cycle not twelve oscillator periods");
	chk_stb_single: assert property (mcycle_stb_o |=> !mcycle_stb_o)
		else $error("strobe longer than one clock");
	chk_half_toggle: assert property ($past(nrst_i, 4) &&
		$past(mode_o) != port_pins_pkg::MODE_PDOWN &&
		$past(mode_o, 2) != port_pins_pkg::MODE_PDOWN |->
		$changed(osc_half_o) == $past(rise[0], 3))
		else $error("divided clock missed an oscillator rise");
	chk_osc_invert: assert property ($past(nrst_i, 4) &&
		$past(mode_o) != port_pins_pkg::MODE_PDOWN |->
		oscillator_output_o == !$past(oscillator_input_i, 3))
		else $error("oscillator output not inverse of input");
	chk_sleep_state: assert property (mode_o != port_pins_pkg::MODE_RUN |->
		!cpu_run_o && periph_run_o == (mode_o == port_pins_pkg::MODE_IDLE))
		else $error("run flags wrong for mode");
	chk_qual_low: assert property (!reset_pin_i [*4] |-> !sys_reset_o)
		else $error("reset stays after pin low");
	chk_qual_min: assert property ($rose(sys_reset_o) |->
		hi_cnt >= 6'd24)
		else $error("reset taken too early");
	chk_qual_take: assert property (hi_cnt >= 6'd40 |-> sys_reset_o)
		else $error("long reset pulse not taken");
	chk_pin_forces: assert property (reset_pin_i [*6] |->
		{drive_o.p1_oe, drive_o.p3_oe} == 16'h0000)
		else $error("latches not forced high");
endmodule

bind port_reset_clock_pins port_pins_properties props (
	.clk_sys_i, .nrst_i, .oscillator_input_i, .reset_pin_i,
	.oscillator_output_o, .osc_half_o,
	.comparator_out_i, .drive_o, .p3_read_o, .mcycle_stb_o, .sys_reset_o,
	.cpu_run_o, .periph_run_o, .mode_o
);

// >>> verif/board_model.sv
`timescale 1ns/1ps
module board_model (
	input  wire logic                      clk_sys_i,
	input  wire port_pins_pkg::pin_drive_t drive_i,
	input  wire logic [7:0]                p1_low_i,
	input  wire logic [7:0]                p3_low_i,
	output logic      [7:0]                p1_pin_o,
	output logic      [7:0]                p3_pin_o,
	output logic                           osc_o
);
	logic [1:0] phase = 2'd0;

	// pull-ups; every bit of p1 and p3 has a resistor fitted on the board
	assign p1_pin_o = (drive_i.p1_oe & drive_i.p1_out) |
		(~drive_i.p1_oe & ~p1_low_i);
	assign p3_pin_o = (drive_i.p3_oe & drive_i.p3_out) |
		(~drive_i.p3_oe & ~p3_low_i);

	// high one clock in four: a skewed duty must not matter
	always @(negedge clk_sys_i) begin
		phase <= phase + 2'd1;
	end
	assign osc_o = (phase == 2'd0);
endmodule

// >>> verif/test_port_reset_clock_pins.sv
`timescale 1ns/1ps
module test_port_reset_clock_pins;
	logic                       clk_sys_i, nrst_i, reset_pin_i;
	logic                       comparator_out_i, serial_tx_i;
	logic                       latch_wr_p1_i, latch_wr_p3_i;
	logic                       idle_req_i, pdown_req_i, irq_pending_i;
	logic                       prog_mode_i, prog_drive_i;
	logic                       oscillator_input_i;
	logic                       cpu_run_o, periph_run_o, sys_reset_o;
	logic [7:0]                 latch_wdata_i, prog_data_i, prog_data_o;
	logic [7:0]                 p1_pin_i, p3_pin_i, p1_read_o, p3_read_o;
	logic [7:0]                 p1_low, p3_low, d, e;
	logic [2:0]                 prog_ctrl_o;
	logic [31:0]                rnd;
	port_pins_pkg::pin_drive_t  drive_o;
	port_pins_pkg::alt_in_t     alt_o;
	port_pins_pkg::power_mode_t mode_o;
	int                         error_cnt, check_count, cyc;

	port_reset_clock_pins dut (
		.clk_sys_i, .nrst_i, .oscillator_input_i, .reset_pin_i, .p1_pin_i,
		.p3_pin_i, .comparator_out_i, .latch_wr_p1_i, .latch_wr_p3_i,
		.latch_wdata_i, .serial_tx_i, .idle_req_i, .pdown_req_i,
		.irq_pending_i, .prog_mode_i, .prog_drive_i, .prog_data_i,
		.oscillator_output_o(), .drive_o, .p1_read_o, .p3_read_o, .alt_o,
		.prog_data_o, .prog_ctrl_o, .osc_half_o(), .mcycle_stb_o(),
		.sys_reset_o, .cpu_run_o, .periph_run_o, .mode_o
	);
	board_model board (
		.clk_sys_i, .drive_i(drive_o), .p1_low_i(p1_low), .p3_low_i(p3_low),
		.p1_pin_o(p1_pin_i), .p3_pin_o(p3_pin_i), .osc_o(oscillator_input_i)
	);

	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			complete_run();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// tx gates bit 1; bit 6 is never driven
	function automatic logic [7:0] p3x(input logic [7:0] v, input logic t);
		return ~(v & {6'h3f, t, 1'b1}) & 8'hbf;
	endfunction
	function automatic logic [6:0] altx(input logic [7:0] a, b);
		return {b[0], b[2], b[3], b[4], b[5], a[0], a[1]};
	endfunction
	task automatic chk(input string n, input logic [7:0] x, g);
		check_count++;
		if (g !== x) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic wr(input logic p3, input logic [7:0] v);
		latch_wr_p1_i = !p3;
		latch_wr_p3_i = p3;
		latch_wdata_i = v;
		wt(1);
		latch_wr_p1_i = 1'b0;
		latch_wr_p3_i = 1'b0;
		wt(6);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		{nrst_i, reset_pin_i, comparator_out_i, idle_req_i} = 4'h0;
		{latch_wr_p1_i, latch_wr_p3_i, pdown_req_i, irq_pending_i} = 4'h0;
		{prog_mode_i, prog_drive_i, serial_tx_i} = 3'b001;
		{latch_wdata_i, prog_data_i, p1_low, p3_low} = 32'h0000_0000;
		rnd = 32'h518f_5486;
		wt(2);
		nrst_i = 1'b1;
		wt(2);
		for (int i = 0; i < 10; i++) begin
			rnd = lfsr(rnd);
			d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : rnd[7:0];
			p1_low = rnd[15:8];
			p3_low = rnd[23:16];
			{serial_tx_i, comparator_out_i} = rnd[25:24];
			wr(1'b0, d);
			wr(1'b1, d);
			e = ~p3x(d, serial_tx_i) & ~p3_low;
			chk("p1 oe", ~d, drive_o.p1_oe);
			chk("p1 read", d & ~p1_low, p1_read_o);
			chk("p3 oe", p3x(d, serial_tx_i), drive_o.p3_oe);
			chk("p3 read", {e[7], comparator_out_i, e[5:0]}, p3_read_o);
			chk("alt", {1'b0, altx(d & ~p1_low, e)}, {1'b0, alt_o});
		end
		$display("ports done");
		serial_tx_i = 1'b1;
		wr(1'b0, 8'hff);
		wr(1'b1, 8'hff);
		{prog_mode_i, prog_drive_i, prog_data_i} = {2'b11, rnd[31:24]};
		wt(6);
		chk("prog out", prog_data_i, drive_o.p1_out);
		chk("prog oe", 8'hff, drive_o.p1_oe);
		chk("prog ctrl", {5'h00, ~p3_low[5:3]}, {5'h00, prog_ctrl_o});
		prog_drive_i = 1'b0;
		wt(6);
		chk("prog in", ~p1_low, prog_data_o);
		prog_mode_i = 1'b0;
		$display("prog done");
		idle_req_i = 1'b1;
		wt(1);
		idle_req_i = 1'b0;
		wt(3);
		chk("idle run", 8'h01, {6'h00, cpu_run_o, periph_run_o});
		wr(1'b0, 8'h00);
		chk("idle write", 8'h00, drive_o.p1_oe);
		irq_pending_i = 1'b1;
		wt(1);
		irq_pending_i = 1'b0;
		wt(3);
		chk("wake", 8'h03, {6'h00, cpu_run_o, periph_run_o});
		$display("idle done");
		wr(1'b0, 8'h0f);
		{pdown_req_i, idle_req_i} = 2'b11;
		wt(1);
		{pdown_req_i, idle_req_i} = 2'b00;
		wt(3);
		chk("pd mode", {6'h00, port_pins_pkg::MODE_PDOWN}, {6'h00, mode_o});
		chk("pd run", 8'h00, {6'h00, cpu_run_o, periph_run_o});
		reset_pin_i = 1'b1;
		wt(8);
		chk("pin force", 8'h00, drive_o.p1_oe);
		wt(64);
		chk("short pulse", 8'h00, {7'h00, sys_reset_o});
		reset_pin_i = 1'b0;
		wt(4);
		chk("still down", {6'h00, port_pins_pkg::MODE_PDOWN},
			{6'h00, mode_o});
		reset_pin_i = 1'b1;
		wt(200);
		chk("qualified", 8'h01, {7'h00, sys_reset_o});
		reset_pin_i = 1'b0;
		wt(6);
		chk("exit", 8'h03, {6'h00, cpu_run_o, periph_run_o});
		$display("reset done");
		complete_run();
	end
endmodule
